// ---- bench/pesc_core_bench.sv ----
// self-checking bench for the event status bank and error counters
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module pesc_core_bench
    import pesc_pkg::*;
;
    logic              mclk;
    logic              reset_n;
    logic              clk_en;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic [10:0]       ev;          // 0..7 status bits 8..15, 8 wake packet, 9 fc, 10 rx
    logic              mii_loopback;
    logic              pin_i;
    logic              fc_half_full;
    logic              rx_half_full;
    logic              pin_oe;
    logic              powerdown_req;
    logic              irq_active;
    int                miscompares;
    int                samples_checked;
    pesc_core i_pesc_core (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .evt_eee_error(ev[7]), .evt_aneg_error(ev[6]), .evt_page_rx(ev[5]),
        .evt_lpbk_fifo(ev[4]), .evt_xover_change(ev[3]), .evt_sleep(ev[2]),
        .evt_polarity(ev[1]), .evt_wol_packet(ev[8]), .evt_jabber(ev[0]),
        .evt_false_carrier(ev[9]), .evt_rx_error(ev[10]), .mii_loopback(mii_loopback),
        .fc_half_full(fc_half_full), .rx_half_full(rx_half_full),
        .irq_or_powerdown_pin_i(pin_i), .irq_or_powerdown_pin_o(),
        .irq_or_powerdown_pin_oe(pin_oe), .powerdown_req(powerdown_req),
        .irq_active(irq_active));
    // clock generation
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // verdict and end of run
    task conclude;
        if (miscompares == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // wait for the edge where waitrequest is sampled low
    task wait_ans;
        @(negedge mclk);
        while (avs_waitrequest !== 1'b0) @(negedge mclk);
        @(posedge mclk);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        wait_ans();
        avs_write      <= 1'b0;
    endtask
    task rc(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        avs_address <= a;
        avs_read    <= 1'b1;
        wait_ans();
        `CHK(avs_readdata, exp)
        avs_read    <= 1'b0;
    endtask
    // hold one event input high for n sampling edges
    task pulse(input int i, input int n);
        @(posedge mclk);
        ev[i] <= 1'b1;
        repeat (n) @(posedge mclk);
        ev[i] <= 1'b0;
        #1;
    endtask
    // watchdog
    initial begin
        repeat (90000) @(posedge mclk);
        miscompares++;
        conclude();
    end
    // main sequence
    initial begin
        miscompares = 0;
        samples_checked = 0;
        clk_en = 1'b1;
        reset_n = 1'b0; avs_address = '0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = '0; avs_byteenable = 4'h0; ev = '0; mii_loopback = 1'b0; pin_i = 1'b1;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rc(ADR_EVT_TWO, 32'h0000_0000);
        rc(ADR_FC_CNT, 32'h0000_0000);
        rc(ADR_RX_CNT, 32'h0000_0000);
        rc(8'h60, UNMAPPED_DATA);
        wr(ADR_EVT_TWO, 32'h0000_00FF, 4'h0);
        rc(ADR_EVT_TWO, 32'h0000_0000);
        wr(ADR_EVT_TWO, 32'h0000_FFFF, 4'hF);
        rc(ADR_EVT_TWO, 32'h0000_00FF);
        for (int i = 0; i < 9; i++) begin
            pulse(i, 1);
            rc(ADR_EVT_TWO, 32'h00FF | (32'h1 << (8 + ((i == 8) ? 1 : i))));
            rc(ADR_EVT_TWO, 32'h0000_00FF);
        end
        wr(ADR_XCVR_CTL, 32'h0000_0003, 4'hF);
        wr(ADR_EVT_TWO, 32'h0000_0002, 4'hF);
        pulse(0, 1);
        `CHK(irq_active, 1'b0)
        pulse(8, 1);
        `CHK(irq_active, 1'b1)
        `CHK(pin_oe, 1'b1)
        rc(ADR_EVT_TWO, 32'h0000_0302);
        #1;
        `CHK(irq_active, 1'b0)
        wr(ADR_XCVR_CTL, 32'h0000_0001, 4'hF);
        pulse(1, 1);
        `CHK(irq_active, 1'b0)
        rc(ADR_EVT_TWO, 32'h0000_0202);
        wr(ADR_XCVR_CTL, 32'h0000_0004, 4'hF);
        #1;
        `CHK(irq_active, 1'b1)
        `CHK(pin_oe, 1'b0)
        @(posedge mclk);
        pin_i <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        `CHK(powerdown_req, 1'b1)
        @(posedge mclk);
        pin_i <= 1'b1;
        pulse(9, 127);
        `CHK(fc_half_full, 1'b0)
        pulse(9, 1);
        `CHK(fc_half_full, 1'b1)
        rc(ADR_FC_CNT, 32'h0000_0080);
        rc(ADR_FC_CNT, 32'h0000_0000);
        pulse(9, 260);
        rc(ADR_FC_CNT, 32'h0000_00FF);
        @(posedge mclk);
        clk_en <= 1'b0;
        pulse(9, 5);
        @(posedge mclk);
        clk_en <= 1'b1;
        rc(ADR_FC_CNT, 32'h0000_0000);
        mii_loopback <= 1'b1;
        pulse(10, 10);
        rc(ADR_RX_CNT, 32'h0000_0000);
        mii_loopback <= 1'b0;
        pulse(10, 127);
        `CHK(rx_half_full, 1'b0)
        pulse(10, 1);
        `CHK(rx_half_full, 1'b1)
        rc(ADR_RX_CNT, 32'h0000_0080);
        pulse(10, 65540);
        rc(ADR_RX_CNT, 32'h0000_FFFF);
        rc(ADR_RX_CNT, 32'h0000_0000);
        conclude();
    end
endmodule // pesc_core_bench

// ---- core/pesc_core.sv ----
// event status bank two, error counters and interrupt pin with Avalon-MM slave
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module pesc_core
    import pesc_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    // event sources, one-cycle pulses from the transceiver core
    input  wire logic              evt_eee_error,
    input  wire logic              evt_aneg_error,
    input  wire logic              evt_page_rx,
    input  wire logic              evt_lpbk_fifo,
    input  wire logic              evt_xover_change,
    input  wire logic              evt_sleep,
    input  wire logic              evt_polarity,
    input  wire logic              evt_wol_packet,
    input  wire logic              evt_jabber,
    input  wire logic              evt_false_carrier,
    input  wire logic              evt_rx_error,
    input  wire logic              mii_loopback,
    // half-full events toward the first status bank
    output logic                   fc_half_full,
    output logic                   rx_half_full,
    // shared interrupt / power-down pin
    input  wire logic              irq_or_powerdown_pin_i,
    output logic                   irq_or_powerdown_pin_o,
    output logic                   irq_or_powerdown_pin_oe,
    output logic                   powerdown_req,
    output logic                   irq_active
);

    // register state
    logic [NUM_EVT-1:0] status_reg;
    logic [NUM_EVT-1:0] enable_reg;
    logic [2:0]         ctl_reg;
    logic [FC_W-1:0]    fc_cnt_reg;
    logic [RX_W-1:0]    rx_cnt_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic               pin_s1_reg;
    logic               pin_s2_reg;
    pesc_bus_e          bus_reg;
    pesc_bus_e          bus_next;

    // address decode
    wire logic sel_evt = (avs_address == ADR_EVT_TWO);
    wire logic sel_fc  = (avs_address == ADR_FC_CNT);
    wire logic sel_rx  = (avs_address == ADR_RX_CNT);
    wire logic sel_ctl = (avs_address == ADR_XCVR_CTL);

    // access is taken once, in the answer state
    wire logic acc    = (bus_reg == ST_ANS) && clk_en;
    wire logic rd_acc = acc && avs_read;
    wire logic wr_acc = acc && avs_write;

    // bus handshake: one wait cycle, done, back to idle
    always_comb begin
        bus_next = bus_reg;
        unique case (bus_reg)
            ST_IDLE: if (avs_read || avs_write) bus_next = ST_ANS;
            ST_ANS:  bus_next = ST_DONE;
            ST_DONE: bus_next = ST_IDLE;
            default: bus_next = ST_IDLE;
        endcase
    end
    // a frozen clock enable must not show an answer that is never taken
    assign avs_waitrequest = !((bus_reg == ST_ANS) && clk_en);

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bus_reg <= ST_IDLE;
        end else if (clk_en) begin
            bus_reg <= bus_next;
        end
    end

    // raw event vector, bit 7 maps to status bit 15
    wire logic [NUM_EVT-1:0] evt_vec = {
        evt_eee_error,
        evt_aneg_error,
        evt_page_rx,
        evt_lpbk_fifo,
        evt_xover_change,
        evt_sleep,
        evt_polarity | evt_wol_packet,
        evt_jabber
    };
    wire logic clr_status = rd_acc && sel_evt;

    // latched status: a new event wins over the read clear
    // only bits returned by the read are cleared, later events stay pending
    genvar gi;
    generate
        for (gi = 0; gi < NUM_EVT; gi++) begin : g_lat
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    status_reg[gi] <= 1'b0;
                end else if (clk_en) begin
                    if (evt_vec[gi]) begin
                        status_reg[gi] <= 1'b1;
                    end else if (clr_status && rdata_reg[EVT_LSB+gi]) begin
                        status_reg[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // enables and control bits, low byte lane only
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            enable_reg <= RST_REG[NUM_EVT-1:0];
            ctl_reg    <= RST_CTL;
        end else if (wr_acc && avs_byteenable[0]) begin
            if (sel_evt) enable_reg <= avs_writedata[NUM_EVT-1:0];
            if (sel_ctl) ctl_reg    <= avs_writedata[2:0];
        end
    end

    // counter increments with saturation, a same-cycle event is added to what the read leaves
    wire logic fc_sat  = (fc_cnt_reg == {FC_W{1'b1}});
    wire logic rx_sat  = (rx_cnt_reg == {RX_W{1'b1}});
    wire logic fc_inc  = evt_false_carrier && !fc_sat;
    wire logic rx_inc  = evt_rx_error && !mii_loopback && !rx_sat;
    wire logic fc_clr  = rd_acc && sel_fc;
    wire logic rx_clr  = rd_acc && sel_rx;

    // a read removes only the count it returned, events after the capture survive
    wire logic [FC_W-1:0] fc_left = fc_cnt_reg - rdata_reg[FC_W-1:0];
    wire logic [RX_W-1:0] rx_left = rx_cnt_reg - rdata_reg[RX_W-1:0];

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            fc_cnt_reg <= RST_REG[FC_W-1:0];
            rx_cnt_reg <= RST_REG;
        end else if (clk_en) begin
            if (fc_clr) fc_cnt_reg <= fc_left + {{(FC_W-1){1'b0}}, evt_false_carrier};
            else if (fc_inc) fc_cnt_reg <= fc_cnt_reg + 8'h01;
            if (rx_clr) rx_cnt_reg <= rx_left +
                {{(RX_W-1){1'b0}}, (evt_rx_error && !mii_loopback)};
            else if (rx_inc) rx_cnt_reg <= rx_cnt_reg + 16'h0001;
        end
    end

    // half-full event levels
    assign fc_half_full = ({8'h00, fc_cnt_reg} > HALF_FULL);
    assign rx_half_full = (rx_cnt_reg > HALF_FULL);

    // read data mux, registered at the edge that leaves idle, one cycle before the answer
    wire logic [DATA_W-1:0] rd_mux =
        sel_evt ? {16'h0000, status_reg, enable_reg} :
        sel_fc  ? {24'h000000, fc_cnt_reg} :
        sel_rx  ? {16'h0000, rx_cnt_reg} :
        sel_ctl ? {29'h0, ctl_reg} : UNMAPPED_DATA;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdata_reg <= UNMAPPED_DATA;
        end else if (clk_en && bus_reg == ST_IDLE && avs_read) begin
            rdata_reg <= rd_mux;
        end
    end
    assign avs_readdata = rdata_reg;

    // interrupt request
    wire logic any_evt = |(status_reg & enable_reg);
    wire logic irq_req = (any_evt && ctl_reg[CTL_GLB_EN])
                       || ctl_reg[CTL_TEST_IRQ];
    assign irq_active = irq_req;

    // shared pin: interrupt drives low only, else sampled as power-down
    assign irq_or_powerdown_pin_o  = 1'b0;
    assign irq_or_powerdown_pin_oe = ctl_reg[CTL_PIN_SEL] && irq_req;
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else if (clk_en) begin
            pin_s1_reg <= irq_or_powerdown_pin_i;
            pin_s2_reg <= pin_s1_reg;
        end
    end
    assign powerdown_req = !ctl_reg[CTL_PIN_SEL] && !pin_s2_reg;

    // checks: event latches set one edge after the event
    a_evt_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_eee_error |=> status_reg[7])
        else $error("eee error not latched");

    a_aneg_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_aneg_error |=> status_reg[6])
        else $error("negotiation error not latched");

    a_page_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_page_rx |=> status_reg[5])
        else $error("page event not latched");

    a_lpbk_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_lpbk_fifo |=> status_reg[4])
        else $error("loopback buffer event not latched");

    a_xover_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_xover_change |=> status_reg[3])
        else $error("pair status change not latched");

    a_sleep_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_sleep |=> status_reg[2])
        else $error("sleep event not latched");

    a_shared_bit_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_wol_packet |=> status_reg[1])
        else $error("wake packet not latched");

    a_polarity_bit_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_polarity |=> status_reg[1])
        else $error("polarity change not latched");

    a_jabber_latch_set: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_jabber |=> status_reg[0])
        else $error("jabber event not latched");

    // checks: latches hold until a read clears them, status word upper half reads zero
    a_eee_bit_stays: assert property (@(posedge mclk) disable iff (!reset_n)
        !clr_status && status_reg[7] |=> status_reg[7])
        else $error("eee error bit dropped");

    a_aneg_bit_stays: assert property (@(posedge mclk) disable iff (!reset_n)
        !clr_status && status_reg[6] |=> status_reg[6])
        else $error("negotiation error bit dropped");

    a_jabber_bit_stays: assert property (@(posedge mclk) disable iff (!reset_n)
        !clr_status && status_reg[0] |=> status_reg[0])
        else $error("jabber bit dropped without read");

    a_read_clears_bits: assert property (@(posedge mclk) disable iff (!reset_n)
        clr_status && evt_vec == 8'h00 && status_reg == rdata_reg[EVT_LSB +: NUM_EVT]
        |=> status_reg == 8'h00)
        else $error("status not cleared by read");

    a_evt_upper_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_reg == ST_ANS && sel_evt && avs_read |-> avs_readdata[31:16] == 16'h0000)
        else $error("status word upper half not zero");

    // checks: enables and control bits change only by a taken write, state freezes with clock enable low, waitrequest low one cycle
    a_enable_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(wr_acc && sel_evt && avs_byteenable[0]) |=> $stable(enable_reg))
        else $error("enables changed without write");

    a_ctl_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        !(wr_acc && sel_ctl && avs_byteenable[0]) |=> $stable(ctl_reg))
        else $error("control bits changed without write");

    a_frozen_state: assert property (@(posedge mclk) disable iff (!reset_n)
        !clk_en |=> $stable(status_reg) && $stable(fc_cnt_reg) && $stable(rx_cnt_reg))
        else $error("state moved with clock enable low");

    a_wait_one_cycle: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_reg == ST_ANS && clk_en |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    // checks: false-carrier counter
    a_fc_count_step: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_false_carrier && !fc_sat && !fc_clr
        |=> fc_cnt_reg == $past(fc_cnt_reg) + 8'h01)
        else $error("false carrier counter did not step");

    a_fc_upper_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        bus_reg == ST_ANS && sel_fc && avs_read |-> avs_readdata[31:8] == 24'h000000)
        else $error("false carrier upper byte not zero");

    a_fc_saturate: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && fc_sat && !fc_clr |=> fc_sat)
        else $error("false carrier counter wrapped");

    a_fc_half_full: assert property (@(posedge mclk) disable iff (!reset_n)
        fc_cnt_reg == 8'h80 |-> fc_half_full)
        else $error("false carrier half-full missing");

    a_fc_half_low: assert property (@(posedge mclk) disable iff (!reset_n)
        fc_cnt_reg == 8'h7F |-> !fc_half_full)
        else $error("false carrier half-full too early");

    a_counter_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        fc_clr && !evt_false_carrier && fc_cnt_reg == rdata_reg[FC_W-1:0]
        |=> fc_cnt_reg == 8'h00)
        else $error("false carrier counter not cleared");

    // checks: receive-error counter
    a_rx_hold_lpbk: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && mii_loopback && !rx_clr |=> $stable(rx_cnt_reg))
        else $error("rx counter moved in loopback");

    a_rx_count_step: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && evt_rx_error && !mii_loopback && !rx_sat && !rx_clr
        |=> rx_cnt_reg == $past(rx_cnt_reg) + 16'h0001)
        else $error("rx counter did not step");

    a_rx_saturate: assert property (@(posedge mclk) disable iff (!reset_n)
        clk_en && rx_sat && !rx_clr |=> rx_sat)
        else $error("rx counter wrapped");

    a_rx_half_full: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_cnt_reg == 16'h007F |-> !rx_half_full)
        else $error("rx half-full too early");

    a_rx_half_high: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_cnt_reg == 16'h0080 |-> rx_half_full)
        else $error("rx half-full missing");

    a_rx_counter_clear: assert property (@(posedge mclk) disable iff (!reset_n)
        rx_clr && !evt_rx_error && rx_cnt_reg == rdata_reg[RX_W-1:0]
        |=> rx_cnt_reg == 16'h0000)
        else $error("rx counter not cleared");

    // checks: interrupt request
    a_polarity_irq: assert property (@(posedge mclk) disable iff (!reset_n)
        ctl_reg[CTL_GLB_EN] && status_reg[1] && enable_reg[1] |-> irq_active)
        else $error("shared bit interrupt missing");

    a_global_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctl_reg[CTL_GLB_EN] && !ctl_reg[CTL_TEST_IRQ] |-> !irq_active)
        else $error("interrupt without global enable");

    a_irq_from_event: assert property (@(posedge mclk) disable iff (!reset_n)
        ctl_reg[CTL_GLB_EN] && (status_reg & enable_reg) != 8'h00 |-> irq_active)
        else $error("enabled event gave no interrupt");

    a_irq_quiet: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctl_reg[CTL_TEST_IRQ] && (status_reg & enable_reg) == 8'h00 |-> !irq_active)
        else $error("interrupt with nothing pending");

    a_test_irq_pin: assert property (@(posedge mclk) disable iff (!reset_n)
        ctl_reg[CTL_TEST_IRQ] && ctl_reg[CTL_PIN_SEL] |-> irq_or_powerdown_pin_oe)
        else $error("test interrupt not driven");

    // checks: shared pin direction
    a_pin_released: assert property (@(posedge mclk) disable iff (!reset_n)
        !ctl_reg[CTL_PIN_SEL] |-> !irq_or_powerdown_pin_oe)
        else $error("pin driven while power-down input");

    a_pin_drives_irq: assert property (@(posedge mclk) disable iff (!reset_n)
        ctl_reg[CTL_PIN_SEL] && irq_active |-> irq_or_powerdown_pin_oe)
        else $error("interrupt not driven on pin");

    a_powerdown_gate: assert property (@(posedge mclk) disable iff (!reset_n)
        ctl_reg[CTL_PIN_SEL] |-> !powerdown_req)
        else $error("power-down while pin is an output");

endmodule // pesc_core

// ---- shared/pesc_pkg.sv ----
// constants for the transceiver event status bank and error counters
package pesc_pkg;
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    // register indices and byte addresses (index times four)
    localparam logic [7:0]  IDX_EVT_TWO   = 8'h13;
    localparam logic [7:0]  IDX_FC_CNT    = 8'h14;
    localparam logic [7:0]  IDX_RX_CNT    = 8'h15;
    localparam logic [7:0]  IDX_XCVR_CTL  = 8'h11;
    localparam logic [7:0]  ADR_EVT_TWO   = 8'h4C;
    localparam logic [7:0]  ADR_FC_CNT    = 8'h50;
    localparam logic [7:0]  ADR_RX_CNT    = 8'h54;
    localparam logic [7:0]  ADR_XCVR_CTL  = 8'h44;
    // field positions
    localparam int          EVT_LSB       = 8;
    localparam int          NUM_EVT       = 8;
    localparam int          CTL_PIN_SEL   = 0;
    localparam int          CTL_GLB_EN    = 1;
    localparam int          CTL_TEST_IRQ  = 2;
    localparam int          FC_W          = 8;
    localparam int          RX_W          = 16;
    // reset values and thresholds
    localparam logic [15:0] RST_REG       = 16'h0000;
    localparam logic [2:0]  RST_CTL       = 3'h0;
    localparam logic [15:0] HALF_FULL     = 16'h007F;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // bus answer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ANS  = 3'b010,
        ST_DONE = 3'b100
    } pesc_bus_e;
endpackage
